// ==== pwm_stretch_pkg.sv ====
package pwm_stretch_pkg;

  localparam int unsigned SHORT_CHANNELS = 6;
  localparam int unsigned LONG_CHANNELS  = 2;
  localparam int unsigned CHANNELS       = SHORT_CHANNELS + LONG_CHANNELS;

  // special function register addresses
  localparam logic [7:0] SHORT_DUTY_BASE_ADDR = 8'hC1;
  localparam logic [7:0] SHORT_DUTY_LAST_ADDR = 8'hC6;
  localparam logic [7:0] LONG_DUTY_CH0_ADDR   = 8'hC7;
  localparam logic [7:0] LONG_DUTY_CH1_ADDR   = 8'hC9;
  localparam logic [7:0] STRETCH_EXT_CH0_ADDR = 8'hCA;
  localparam logic [7:0] STRETCH_EXT_CH1_ADDR = 8'hCB;

  localparam logic [7:0] REG_RESET_VALUE = 8'h00;

  // field positions
  localparam int unsigned DIRECT_RATE_BIT    = 1;
  localparam int unsigned HALF_RATE_BIT      = 0;
  localparam logic [7:0]  EXT_CH1_WRITE_MASK = 8'hFC;

  // counter fields
  localparam int unsigned COUNTER_WIDTH   = 14;
  localparam int unsigned SHORT_POS_WIDTH = 6;
  localparam int unsigned LONG_POS_WIDTH  = 8;
  localparam int unsigned SHORT_IDX_WIDTH = 2;
  localparam int unsigned LONG_IDX_WIDTH  = 6;

  // clocks per count minus one: direct, normal, halved
  localparam logic [1:0] DIV_DIRECT_LAST = 2'h0;
  localparam logic [1:0] DIV_NORMAL_LAST = 2'h1;
  localparam logic [1:0] DIV_HALF_LAST   = 2'h3;

endpackage

// ==== pwm_channel_cmp.sv ====
`timescale 1ns/100ps
module pwm_channel_cmp #(
  parameter bit LONG_RES = 1'b0
) (
  // clock and reset
  input  wire logic       sys_clk_i,
  input  wire logic       reset_i,
  // active settings
  input  wire logic [7:0] compare_i,
  input  wire logic [7:0] stretch_ext_i,
  input  wire logic       enable_i,
  // shared counter
  input  wire logic [pwm_stretch_pkg::COUNTER_WIDTH-1:0] counter_i,
  // pin drive
  output logic            pwm_out_o
);
  import pwm_stretch_pkg::*;

  logic [8:0] base_high;
  logic       stretch;
  logic [8:0] threshold;
  logic [8:0] position;

  always_comb begin
    stretch = 1'b0;
    if (LONG_RES) begin
      base_high = {1'b0, compare_i};
      position  = {1'b0, counter_i[LONG_POS_WIDTH-1:0]};
      // lowest set index bit k picks extension bit 7-k, spreading stretches apart
      for (int k = LONG_IDX_WIDTH - 1; k >= 0; k--) begin
        if (counter_i[LONG_POS_WIDTH + k]) begin
          stretch = stretch_ext_i[7 - k];
        end
      end
    end else begin
      base_high = {3'h0, compare_i[7:2]};
      position  = {3'h0, counter_i[SHORT_POS_WIDTH-1:0]};
      if (counter_i[SHORT_POS_WIDTH]) begin
        stretch = compare_i[1];
      end else if (counter_i[SHORT_POS_WIDTH + 1]) begin
        stretch = compare_i[0];
      end
    end
    threshold = base_high + {8'h00, stretch};
  end

  // high from the start of each base cycle until the position reaches the threshold;
  // a zero threshold never raises the pin
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      pwm_out_o <= 1'b0;
    end else begin
      pwm_out_o <= enable_i && (position < threshold);
    end
  end

endmodule

// ==== pwm_compare_stretch.sv ====
`timescale 1ns/100ps
module pwm_compare_stretch (
  // clock and reset
  input  wire logic        sys_clk_i,
  input  wire logic        reset_i,
  // special function register port
  input  wire logic [7:0]  sfr_addr_i,
  input  wire logic [7:0]  sfr_wdata_i,
  input  wire logic        sfr_wr_i,
  input  wire logic        sfr_rd_i,
  output logic      [7:0]  sfr_rdata_o,
  // shared counter side
  input  wire logic [pwm_stretch_pkg::COUNTER_WIDTH-1:0] counter_i,
  input  wire logic        counter_ovf_i,
  input  wire logic [pwm_stretch_pkg::CHANNELS-1:0]      channel_enable_i,
  output logic             count_tick_o,
  // channel pins
  output logic      [pwm_stretch_pkg::CHANNELS-1:0]      pwm_out_o
);
  import pwm_stretch_pkg::*;

  logic [7:0] shadow_duty_ff  [CHANNELS];
  logic [7:0] active_duty_ff  [CHANNELS];
  logic [7:0] shadow_ext_ff   [LONG_CHANNELS];
  logic [7:0] active_ext_ff   [LONG_CHANNELS];
  logic [1:0] div_cnt_ff;
  logic [1:0] div_last;
  logic       load_active;
  logic [7:0] nxt_rdata;

  // all disabled means the counter is stopped, so loading cannot tear a cycle
  assign load_active = counter_ovf_i || (channel_enable_i == '0);

  // shadow registers, written at any time
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        shadow_duty_ff[i] <= REG_RESET_VALUE;
      end
      for (int i = 0; i < LONG_CHANNELS; i++) begin
        shadow_ext_ff[i] <= REG_RESET_VALUE;
      end
    end else if (sfr_wr_i) begin
      if (sfr_addr_i >= SHORT_DUTY_BASE_ADDR && sfr_addr_i <= SHORT_DUTY_LAST_ADDR) begin
        shadow_duty_ff[3'(sfr_addr_i - SHORT_DUTY_BASE_ADDR)] <= sfr_wdata_i;
      end
      if (sfr_addr_i == LONG_DUTY_CH0_ADDR) begin
        shadow_duty_ff[SHORT_CHANNELS] <= sfr_wdata_i;
      end
      if (sfr_addr_i == LONG_DUTY_CH1_ADDR) begin
        shadow_duty_ff[SHORT_CHANNELS + 1] <= sfr_wdata_i;
      end
      if (sfr_addr_i == STRETCH_EXT_CH0_ADDR) begin
        shadow_ext_ff[0] <= sfr_wdata_i;
      end
      if (sfr_addr_i == STRETCH_EXT_CH1_ADDR) begin
        // reserved low bits kept at zero
        shadow_ext_ff[1] <= sfr_wdata_i & EXT_CH1_WRITE_MASK;
      end
    end
  end

  // active copies feed the comparators
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      for (int i = 0; i < CHANNELS; i++) begin
        active_duty_ff[i] <= REG_RESET_VALUE;
      end
      for (int i = 0; i < LONG_CHANNELS; i++) begin
        active_ext_ff[i] <= REG_RESET_VALUE;
      end
    end else if (load_active) begin
      active_duty_ff <= shadow_duty_ff;
      active_ext_ff  <= shadow_ext_ff;
    end
  end

  // counting rate from the active direct and halving bits
  always_comb begin
    if (active_ext_ff[0][DIRECT_RATE_BIT]) begin
      div_last = DIV_DIRECT_LAST;
    end else if (active_ext_ff[0][HALF_RATE_BIT]) begin
      div_last = DIV_HALF_LAST;
    end else begin
      div_last = DIV_NORMAL_LAST;
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      div_cnt_ff <= 2'h0;
    end else if (div_cnt_ff >= div_last) begin
      div_cnt_ff <= 2'h0;
    end else begin
      div_cnt_ff <= div_cnt_ff + 2'h1;
    end
  end

  // one tick serves channels and timer mode alike
  assign count_tick_o = (div_cnt_ff >= div_last);

  // read back of shadow values, unmapped reads zero
  always_comb begin
    nxt_rdata = 8'h00;
    if (sfr_addr_i >= SHORT_DUTY_BASE_ADDR && sfr_addr_i <= SHORT_DUTY_LAST_ADDR) begin
      nxt_rdata = shadow_duty_ff[3'(sfr_addr_i - SHORT_DUTY_BASE_ADDR)];
    end else if (sfr_addr_i == LONG_DUTY_CH0_ADDR) begin
      nxt_rdata = shadow_duty_ff[SHORT_CHANNELS];
    end else if (sfr_addr_i == LONG_DUTY_CH1_ADDR) begin
      nxt_rdata = shadow_duty_ff[SHORT_CHANNELS + 1];
    end else if (sfr_addr_i == STRETCH_EXT_CH0_ADDR) begin
      nxt_rdata = shadow_ext_ff[0];
    end else if (sfr_addr_i == STRETCH_EXT_CH1_ADDR) begin
      nxt_rdata = shadow_ext_ff[1];
    end
  end

  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i) begin
      sfr_rdata_o <= 8'h00;
    end else if (sfr_rd_i) begin
      sfr_rdata_o <= nxt_rdata;
    end
  end

  // one comparator per channel
  for (genvar ch = 0; ch < CHANNELS; ch++) begin : g_chan
    pwm_channel_cmp #(
      .LONG_RES (ch >= SHORT_CHANNELS)
    ) u_cmp (
      .sys_clk_i     (sys_clk_i),
      .reset_i       (reset_i),
      .compare_i     (active_duty_ff[ch]),
      .stretch_ext_i (active_ext_ff[(ch >= SHORT_CHANNELS) ? ch - SHORT_CHANNELS : 0]),
      .enable_i      (channel_enable_i[ch]),
      .counter_i     (counter_i),
      .pwm_out_o     (pwm_out_o[ch])
    );
  end

endmodule

// ==== pwm_load_model.sv ====
`timescale 1ns/100ps
module pwm_load_model (
  // clock and control
  input  wire logic       sys_clk_i,
  input  wire logic       clear_i,
  // driven pins
  input  wire logic [7:0] pin_i,
  output int              high_cnt_o [8]
);
  // integrates high time per pin, as a filtered load would
  always_ff @(posedge sys_clk_i) begin
    for (int k = 0; k < 8; k++) begin
      high_cnt_o[k] <= clear_i ? 0 : high_cnt_o[k] + int'(pin_i[k]);
    end
  end
endmodule

// ==== pwm_compare_stretch_sva.sv ====
`timescale 1ns/100ps
module pwm_compare_stretch_chk
  import pwm_stretch_pkg::*;
(
  // clock and reset
  input wire logic       sys_clk_i,
  input wire logic       reset_i,
  // register port
  input wire logic [7:0] sfr_addr_i,
  input wire logic [7:0] sfr_wdata_i,
  input wire logic       sfr_wr_i,
  input wire logic       sfr_rd_i,
  input wire logic [7:0] sfr_rdata_o,
  // enables, rate and pins
  input wire logic [7:0] channel_enable_i,
  input wire logic       count_tick_o,
  input wire logic [7:0] pwm_out_o
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (reset_i);
  logic direct_seen_ff;
  // spacing only holds until direct rate was ever asked for
  always_ff @(posedge sys_clk_i or posedge reset_i) begin
    if (reset_i)
      direct_seen_ff <= 1'b0;
    else if (sfr_wr_i && sfr_addr_i == STRETCH_EXT_CH0_ADDR && sfr_wdata_i[DIRECT_RATE_BIT])
      direct_seen_ff <= 1'b1;
  end
  property p_off; (pwm_out_o & ~$past(channel_enable_i)) == 8'h00; endproperty
  a_off: assert property (p_off) else $error("disabled pin high");
  property p_gap; count_tick_o |-> ##[1:4] count_tick_o; endproperty
  a_gap: assert property (p_gap) else $error("tick missing");
  property p_spaced; count_tick_o && !direct_seen_ff |=> !count_tick_o; endproperty
  a_spaced: assert property (p_spaced) else $error("tick too fast");
  property p_hold; !sfr_rd_i |=> $stable(sfr_rdata_o); endproperty
  a_hold: assert property (p_hold) else $error("read data moved");
  property p_rsv; sfr_rd_i && sfr_addr_i == 8'hCB |=> sfr_rdata_o[1:0] == 2'h0; endproperty
  a_rsv: assert property (p_rsv) else $error("reserved bits set");
  property p_ext1;
    sfr_wr_i && sfr_addr_i == 8'hCB ##1 sfr_rd_i && sfr_addr_i == 8'hCB
      |=> sfr_rdata_o == ($past(sfr_wdata_i, 2) & EXT_CH1_WRITE_MASK); endproperty
  a_ext1: assert property (p_ext1) else $error("ext1 readback");
  property p_ext0;
    sfr_wr_i && sfr_addr_i == 8'hCA ##1 sfr_rd_i && sfr_addr_i == 8'hCA
      |=> sfr_rdata_o == $past(sfr_wdata_i, 2); endproperty
  a_ext0: assert property (p_ext0) else $error("ext0 readback");
  property p_long;
    sfr_wr_i && sfr_addr_i == 8'hC7 ##1 sfr_rd_i && sfr_addr_i == 8'hC7
      |=> sfr_rdata_o == $past(sfr_wdata_i, 2); endproperty
  a_long: assert property (p_long) else $error("long readback");
endmodule
bind pwm_compare_stretch pwm_compare_stretch_chk chk (.sys_clk_i, .reset_i, .sfr_addr_i,
  .sfr_wdata_i, .sfr_wr_i, .sfr_rd_i, .sfr_rdata_o, .channel_enable_i, .count_tick_o,
  .pwm_out_o);

// ==== testbench.sv ====
`timescale 1ns/100ps
module testbench;
  import pwm_stretch_pkg::*;
  logic        sys_clk_i = 1'b0;
  logic        reset_i = 1'b1;
  logic [7:0]  addr = 8'h00, wdata = 8'h00, enable = 8'h00, rdata, pins, e;
  logic        wr = 1'b0, rd = 1'b0, ovf = 1'b0, clr = 1'b0, tick;
  logic [13:0] cnt = 14'h0000;
  logic [7:0]  regs [11] = '{8'hC1, 8'hC2, 8'hC3, 8'hC4, 8'hC5, 8'hC6, 8'hC7, 8'hC8, 8'hC9,
                             8'hCA, 8'hCB};
  logic [7:0]  cfg [11] = '{8'h0B, 8'hFF, 8'h00, 8'h01, 8'h40, 8'h02, 8'h80, 8'h00, 8'h00,
                            8'hA4, 8'hFF};
  int          hc [8], n, miscompares = 0, cmp_count = 0;
  int          want [8] = '{704, 16320, 0, 64, 0, 128, 8233, 63};
  always #5 sys_clk_i = ~sys_clk_i;
  pwm_compare_stretch uut (.sys_clk_i, .reset_i, .sfr_addr_i(addr), .sfr_wdata_i(wdata),
    .sfr_wr_i(wr), .sfr_rd_i(rd), .sfr_rdata_o(rdata), .counter_i(cnt), .counter_ovf_i(ovf),
    .channel_enable_i(enable), .count_tick_o(tick), .pwm_out_o(pins));
  pwm_load_model load (.sys_clk_i, .clear_i(clr), .pin_i(pins), .high_cnt_o(hc));
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    cmp_count++;
    if (got !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  // both bus tasks start and end at a falling edge, so calls run back to back
  task automatic wr_reg(logic [7:0] a, logic [7:0] d);
    addr = a;
    wdata = d;
    wr = 1'b1;
    @(negedge sys_clk_i);
    wr = 1'b0;
  endtask
  task automatic rd_chk(logic [7:0] a, logic [7:0] x);
    addr = a;
    rd = 1'b1;
    @(negedge sys_clk_i);
    rd = 1'b0;
    chk($sformatf("reg %h", a), 16'(x), 16'(rdata));
  endtask
  task automatic rate(logic [7:0] ca, int x);
    wr_reg(8'hCA, ca);
    repeat (4) @(negedge sys_clk_i);
    n = 0;
    repeat (40) begin
      @(negedge sys_clk_i);
      n += int'(tick);
    end
    chk("ticks", 16'(x), 16'(n));
  endtask
  task automatic conclude;
    $display("comparisons %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    #400000;
    miscompares++;
    conclude();
  end
  initial begin
    repeat (12) @(negedge sys_clk_i);
    reset_i = 1'b0;
    @(negedge sys_clk_i);
    foreach (regs[k]) rd_chk(regs[k], 8'h00);
    rate(8'h00, 20);
    rate(8'h01, 10);
    rate(8'h03, 40);
    rate(8'h02, 40);
    foreach (regs[k]) begin
      e = regs[k] == 8'hC8 ? 8'h00 : regs[k] == 8'hCB ? 8'hA4 : 8'hA7;
      wr_reg(regs[k], 8'hA7);
      rd_chk(regs[k], e);
    end
    // settings load at once while every channel is idle
    foreach (regs[k]) wr_reg(regs[k], cfg[k]);
    enable = 8'hEF;
    for (int i = 0; i <= 16384; i++) begin
      cnt = i[13:0];
      ovf = i[13:0] == 14'h0000;
      clr = i == 0;
      @(negedge sys_clk_i);
    end
    enable = 8'h00;
    foreach (want[k]) chk($sformatf("high ch%0d", k), 16'(want[k]), 16'(hc[k]));
    conclude();
  end
endmodule
